// >>> verilog/gpfg_pkg.sv
// constants for the port f and port g general-purpose i/o block
package gpfg_pkg;
  // register byte addresses
  localparam logic [11:0] ADDR_F_LATCH = 12'h000;
  localparam logic [11:0] ADDR_F_DIR = 12'h004;
  localparam logic [11:0] ADDR_G_LATCH = 12'h008;
  localparam logic [11:0] ADDR_G_DIR = 12'h00c;
  localparam logic [11:0] ADDR_G_PULLUP = 12'h010;
  localparam logic [11:0] ADDR_CTRL = 12'h014;
  localparam logic [11:0] ADDR_RMW_READ = 12'h018;
  // field positions in the control register
  localparam int CTRL_FLOAT_BIT = 0;
  localparam int CTRL_RST_SEL_BIT = 1;
  localparam int CTRL_STOP_BIT = 2;
  localparam int CTRL_WATCH_BIT = 3;
  // implemented bit masks
  localparam logic [7:0] F_MASK = 8'h07;
  localparam logic [7:0] G_MASK = 8'h06;
  localparam int F_RST_PIN = 2;
  // reset values
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] PULLUP_RESET = 8'h00;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    GPFG_W_IDLE = 2'b00,
    GPFG_W_RESP = 2'b01
  } gpfg_wstate_t;
endpackage

// >>> verilog/gpfg_top.sv
// port f / port g general-purpose i/o with an axi4-lite register slave
// Functional notes
// - port f pin is output when its direction bit is one, else input
// - port g pin is output when its direction bit is one, else input
// - output pin drives its output latch bit
// - data write always updates latch; input pins do not drive it
// - data read returns latch for output pins
// - input pins read pin level; read-modify-write read returns latch
// - reset clears all port f direction bits
// - reset clears all port g direction bits
// - float bit set in stop or watch: pins float, inputs forced low
// - float bit clear in stop or watch: pins keep their state
// - port g pull-up bit connects the internal pull-up
// - port g pull-up is off while the pin drives low
// - open-drain output with latch one floats instead of driving high
// - external reset select makes port f bit 2 the reset input
// - port f implements bits 0 to 2 only
// - port g implements bits 1 and 2 only
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ns
module gpfg_top #(
  parameter logic [7:0] F_OPEN_DRAIN = 8'h00,
  parameter logic [7:0] G_OPEN_DRAIN = 8'h00
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port f pins
  input wire logic [2:0] port_f_in,
  output logic [2:0] port_f_out,
  output logic [2:0] port_f_oe,
  // port g pins
  input wire logic [2:1] port_g_in,
  output logic [2:1] port_g_out,
  output logic [2:1] port_g_oe,
  output logic [2:1] port_g_pullup_on,
  // reset pin function and blocked internal inputs
  output logic ext_reset_sel,
  output logic [2:0] port_f_int_in,
  output logic [2:1] port_g_int_in
);

  logic [7:0] f_latch_q, f_dir_q, g_latch_q, g_dir_q, g_pull_q;
  logic [3:0] ctrl_q;
  logic [2:0] f_sync1_q, f_sync2_q;
  logic [2:1] g_sync1_q, g_sync2_q;
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [2:0] f_out_q, f_oe_q, f_int_q;
  logic [2:1] g_out_q, g_oe_q, g_pu_q, g_int_q;
  logic rst_sel_q;

  // merge read data: latch for outputs, pin for inputs
  function automatic logic [7:0] port_read(input logic [7:0] latch, input logic [7:0] dir,
                                           input logic [7:0] pin, input logic [7:0] mask);
    port_read = ((latch & dir) | (pin & ~dir)) & mask;
  endfunction

  // pin level seen inside, padded to eight bits
  wire [7:0] f_pin8 = {5'h00, f_sync2_q};
  wire [7:0] g_pin8 = {5'h00, g_sync2_q, 1'b0};

  // standby float condition
  wire standby = ctrl_q[gpfg_pkg::CTRL_STOP_BIT] | ctrl_q[gpfg_pkg::CTRL_WATCH_BIT];
  wire float_all = standby & ctrl_q[gpfg_pkg::CTRL_FLOAT_BIT];

  // write path: both channels captured, then committed together
  wire aw_ok = aw_hold_q | s_axi_awvalid;
  wire w_ok = w_hold_q | s_axi_wvalid;
  wire [11:0] wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_hold_q ? wdata_q : s_axi_wdata;
  wire [3:0] wr_strb = w_hold_q ? wstrb_q : s_axi_wstrb;
  wire wr_fire = clk_en & aw_ok & w_ok & ~bvalid_q;
  // only byte lane 0 carries register bits
  wire wr_lane0 = wr_fire & wr_strb[0];
  wire [7:0] wb = wr_data[7:0];
  wire wr_f_latch = wr_lane0 & (wr_addr == gpfg_pkg::ADDR_F_LATCH);
  wire wr_f_dir = wr_lane0 & (wr_addr == gpfg_pkg::ADDR_F_DIR);
  wire wr_g_latch = wr_lane0 & (wr_addr == gpfg_pkg::ADDR_G_LATCH);
  wire wr_g_dir = wr_lane0 & (wr_addr == gpfg_pkg::ADDR_G_DIR);
  wire wr_g_pull = wr_lane0 & (wr_addr == gpfg_pkg::ADDR_G_PULLUP);
  wire wr_ctrl = wr_lane0 & (wr_addr == gpfg_pkg::ADDR_CTRL);
  wire wr_hit = (wr_addr == gpfg_pkg::ADDR_F_LATCH) | (wr_addr == gpfg_pkg::ADDR_F_DIR)
              | (wr_addr == gpfg_pkg::ADDR_G_LATCH) | (wr_addr == gpfg_pkg::ADDR_G_DIR)
              | (wr_addr == gpfg_pkg::ADDR_G_PULLUP) | (wr_addr == gpfg_pkg::ADDR_CTRL);

  // read path: one address taken while no answer is pending
  wire rd_fire = clk_en & s_axi_arvalid & ~rvalid_q;
  wire [11:0] ra = s_axi_araddr;
  // pin for inputs, latch for outputs
  wire [7:0] f_norm = port_read(f_latch_q, f_dir_q, f_pin8, gpfg_pkg::F_MASK);
  wire [7:0] g_norm = port_read(g_latch_q, g_dir_q, g_pin8, gpfg_pkg::G_MASK);
  // rmw window: latches of both ports, f in byte 0, g in byte 1
  wire [31:0] rmw_word = {16'h0000, g_latch_q & gpfg_pkg::G_MASK, f_latch_q & gpfg_pkg::F_MASK};
  wire rd_hit = (ra == gpfg_pkg::ADDR_F_LATCH) | (ra == gpfg_pkg::ADDR_F_DIR)
              | (ra == gpfg_pkg::ADDR_G_LATCH) | (ra == gpfg_pkg::ADDR_G_DIR)
              | (ra == gpfg_pkg::ADDR_G_PULLUP) | (ra == gpfg_pkg::ADDR_CTRL)
              | (ra == gpfg_pkg::ADDR_RMW_READ);
  wire [31:0] rd_word =
      (ra == gpfg_pkg::ADDR_F_LATCH) ? {24'h000000, f_norm} :
      (ra == gpfg_pkg::ADDR_F_DIR) ? {24'h000000, f_dir_q} :
      (ra == gpfg_pkg::ADDR_G_LATCH) ? {24'h000000, g_norm} :
      (ra == gpfg_pkg::ADDR_G_DIR) ? {24'h000000, g_dir_q} :
      (ra == gpfg_pkg::ADDR_G_PULLUP) ? {24'h000000, g_pull_q} :
      (ra == gpfg_pkg::ADDR_CTRL) ? {28'h0000000, ctrl_q} :
      (ra == gpfg_pkg::ADDR_RMW_READ) ? rmw_word : 32'h00000000;

  // pin drive logic
  // port f direction
  // bit 2 released as reset input
  wire [2:0] f_od = F_OPEN_DRAIN[2:0];
  wire [2:0] f_gpio = {~ctrl_q[gpfg_pkg::CTRL_RST_SEL_BIT], 2'b11};
  wire [2:0] f_drive = f_dir_q[2:0] & f_gpio & ~(f_od & f_latch_q[2:0]);
  wire [2:1] g_od = G_OPEN_DRAIN[2:1];
  wire [2:1] g_drive = g_dir_q[2:1] & ~(g_od & g_latch_q[2:1]);
  wire [2:1] g_drive_low = g_drive & ~g_latch_q[2:1];

  // pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      f_sync1_q <= 3'h0;
      f_sync2_q <= 3'h0;
      g_sync1_q <= 2'h0;
      g_sync2_q <= 2'h0;
    end else if (clk_en) begin
      f_sync1_q <= port_f_in;
      f_sync2_q <= f_sync1_q;
      g_sync1_q <= port_g_in;
      g_sync2_q <= g_sync1_q;
    end
  end

  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      f_latch_q <= gpfg_pkg::LATCH_RESET;
      f_dir_q <= gpfg_pkg::DIR_RESET;
      g_latch_q <= gpfg_pkg::LATCH_RESET;
      g_dir_q <= gpfg_pkg::DIR_RESET;
      g_pull_q <= gpfg_pkg::PULLUP_RESET;
      ctrl_q <= gpfg_pkg::CTRL_RESET;
    end else begin
      if (wr_f_latch) f_latch_q <= wb & gpfg_pkg::F_MASK;
      if (wr_f_dir) f_dir_q <= wb & gpfg_pkg::F_MASK;
      if (wr_g_latch) g_latch_q <= wb & gpfg_pkg::G_MASK;
      if (wr_g_dir) g_dir_q <= wb & gpfg_pkg::G_MASK;
      if (wr_g_pull) g_pull_q <= wb & gpfg_pkg::G_MASK;
      if (wr_ctrl) ctrl_q <= wb[3:0];
    end
  end

  // axi write channel handling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= gpfg_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? gpfg_pkg::RESP_OKAY : gpfg_pkg::RESP_SLVERR;
      end else begin
        if (s_axi_awvalid & ~aw_hold_q & ~bvalid_q) begin
          aw_hold_q <= 1'b1;
          awaddr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid & ~w_hold_q & ~bvalid_q) begin
          w_hold_q <= 1'b1;
          wdata_q <= s_axi_wdata;
          wstrb_q <= s_axi_wstrb;
        end
        if (bvalid_q & s_axi_bready) bvalid_q <= 1'b0;
      end
    end
  end

  // axi read channel handling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= gpfg_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? gpfg_pkg::RESP_OKAY : gpfg_pkg::RESP_SLVERR;
      end else if (rvalid_q & s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // registered pin outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      f_out_q <= 3'h0;
      f_oe_q <= 3'h0;
      g_out_q <= 2'h0;
      g_oe_q <= 2'h0;
      g_pu_q <= 2'h0;
      f_int_q <= 3'h0;
      g_int_q <= 2'h0;
      rst_sel_q <= 1'b0;
    end else if (clk_en) begin
      f_out_q <= f_latch_q[2:0];
      g_out_q <= g_latch_q[2:1];
      f_oe_q <= float_all ? 3'h0 : f_drive;
      g_oe_q <= float_all ? 2'h0 : g_drive;
      f_int_q <= float_all ? 3'h0 : f_sync2_q;
      g_int_q <= float_all ? 2'h0 : g_sync2_q;
      g_pu_q <= g_pull_q[2:1] & ~(float_all ? 2'h0 : g_drive_low);
      rst_sel_q <= ctrl_q[gpfg_pkg::CTRL_RST_SEL_BIT];
    end
  end

  // port f bit 2 drive is gated off in hardware while reset select is set
  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready = ~w_hold_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign port_f_out = f_out_q;
  assign port_f_oe = f_oe_q;
  assign port_g_out = g_out_q;
  assign port_g_oe = g_oe_q;
  assign port_g_pullup_on = g_pu_q;
  assign port_f_int_in = f_int_q;
  assign port_g_int_in = g_int_q;
  assign ext_reset_sel = rst_sel_q;

endmodule

// >>> dv/gpfg_props.sv
// assertion checker for the port f/g block
`timescale 1ns/1ns
module gpfg_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pin side
  input wire logic [2:0] port_f_oe,
  input wire logic [2:1] port_g_out,
  input wire logic [2:1] port_g_oe,
  input wire logic [2:1] port_g_pullup_on,
  input wire logic ext_reset_sel
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_write_answer:
  assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en |=> s_axi_bvalid)
    else $error("write not answered");
  a_read_answer:
  assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid) else $error("read not answered");
  a_bresp_hold:
  assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_hold:
  assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_read_refused:
  assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_dir_reset:
  assert property ($rose(aresetn) |-> port_f_oe == 3'h0 && port_g_oe == 2'h0) else $error("pins driven after reset");
  a_low_no_pull:
  assert property (!(|(port_g_oe & ~port_g_out & port_g_pullup_on))) else $error("pull-up on low pin");
  a_reset_pin:
  assert property (ext_reset_sel && $past(ext_reset_sel) |-> !port_f_oe[2]) else $error("reset pin driven");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (ext_reset_sel);
endmodule
bind gpfg_top gpfg_props gpfg_props_i (.*);

// >>> dv/gpfg_pin_model.sv
// far-side pin model: external drivers and pull-ups
`timescale 1ns/1ns
module gpfg_pin_model (
  // clock
  input wire logic aclk,
  // design pin side
  input wire logic [2:0] port_f_out,
  input wire logic [2:0] port_f_oe,
  input wire logic [2:1] port_g_out,
  input wire logic [2:1] port_g_oe,
  input wire logic [2:1] port_g_pullup_on,
  // external drivers
  input wire logic [2:0] f_ext,
  input wire logic [2:0] f_ext_en,
  input wire logic [2:1] g_ext,
  input wire logic [2:1] g_ext_en,
  // resolved levels
  output logic [2:0] port_f_in,
  output logic [2:1] port_g_in
);
  logic wander_q = 1'b0;
  // open pin with no pull wanders, so nothing trusts it
  always_ff @(posedge aclk) wander_q <= ~wander_q;
  // far side yields to output pins
  assign port_f_in = (port_f_oe & port_f_out)
    | (~port_f_oe & ((f_ext_en & f_ext) | (~f_ext_en & {3{wander_q}})));
  // pull-up holds an open pin high
  assign port_g_in = (port_g_oe & port_g_out)
    | (~port_g_oe & ((g_ext_en & g_ext) | (~g_ext_en & (port_g_pullup_on | {2{wander_q}}))));
endmodule

// >>> dv/gpio_ports_f_and_g_tb_top.sv
// self-checking bench for the port f/g block
`timescale 1ns/1ns
module gpio_ports_f_and_g_tb_top;
  logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ext_reset_sel;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] port_f_in, port_f_out, port_f_oe, port_f_int_in, f_ext, f_ext_en;
  logic [2:1] port_g_in, port_g_out, port_g_oe, port_g_pullup_on, port_g_int_in, g_ext, g_ext_en;
  int errors, check_count;
  gpfg_top gpfg_top_i (.*);
  gpfg_pin_model gpfg_pin_model_i (.*);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, bv, got;
    got = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!got) begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      bv = s_axi_bvalid;
      got = bv && s_axi_bready;
      if (got) chk("bresp", 32'(s_axi_bresp), 32'(er));
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      // late ready keeps the response standing a cycle
      s_axi_bready <= bv && !got;
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ha, rv, got;
    got = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!got) begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      got = rv && s_axi_rready;
      if (got) chk("rresp", 32'(s_axi_rresp), 32'(er));
      if (got) chk("rdata", s_axi_rdata, e);
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
      s_axi_rready <= rv && !got;
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge aclk);
    errors++;
    end_sim();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {clk_en, s_axi_wstrb} = 5'h1f;
    {f_ext, f_ext_en, g_ext, g_ext_en} = 10'h038;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(gpfg_pkg::ADDR_F_DIR, 32'h0, gpfg_pkg::RESP_OKAY);
    rd(gpfg_pkg::ADDR_G_DIR, 32'h0, gpfg_pkg::RESP_OKAY);
    rd(12'h01c, 32'h0, gpfg_pkg::RESP_SLVERR);
    wr(12'h01c, 32'hff, gpfg_pkg::RESP_SLVERR);
    wr(gpfg_pkg::ADDR_F_DIR, 32'hff, gpfg_pkg::RESP_OKAY);
    rd(gpfg_pkg::ADDR_F_DIR, 32'h7, gpfg_pkg::RESP_OKAY);
    wr(gpfg_pkg::ADDR_G_DIR, 32'hff, gpfg_pkg::RESP_OKAY);
    rd(gpfg_pkg::ADDR_G_DIR, 32'h6, gpfg_pkg::RESP_OKAY);
    wr(gpfg_pkg::ADDR_F_DIR, 32'h5, gpfg_pkg::RESP_OKAY);
    wr(gpfg_pkg::ADDR_F_LATCH, 32'hff, gpfg_pkg::RESP_OKAY);
    wr(gpfg_pkg::ADDR_G_DIR, 32'h2, gpfg_pkg::RESP_OKAY);
    wr(gpfg_pkg::ADDR_G_LATCH, 32'h0, gpfg_pkg::RESP_OKAY);
    wr(gpfg_pkg::ADDR_G_PULLUP, 32'hff, gpfg_pkg::RESP_OKAY);
    rd(gpfg_pkg::ADDR_F_LATCH, 32'h5, gpfg_pkg::RESP_OKAY);
    rd(gpfg_pkg::ADDR_G_LATCH, 32'h4, gpfg_pkg::RESP_OKAY);
    rd(gpfg_pkg::ADDR_RMW_READ, 32'h7, gpfg_pkg::RESP_OKAY);
    chk("f_oe", 32'(port_f_oe), 32'h5);
    chk("f_out", 32'(port_f_out & port_f_oe), 32'h5);
    chk("g_oe", 32'(port_g_oe), 32'h1);
    chk("g_pull", 32'(port_g_pullup_on), 32'h2);
    f_ext <= 3'h7;
    for (int i = 0; i < 2; i++) begin
      wr(gpfg_pkg::ADDR_CTRL, (i != 0) ? 32'h9 : 32'h5, gpfg_pkg::RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("float_oe", 32'({port_f_oe, port_g_oe, port_f_int_in, port_g_int_in}), 32'h0);
    end
    wr(gpfg_pkg::ADDR_CTRL, 32'h4, gpfg_pkg::RESP_OKAY);
    chk("stop_oe", 32'({port_f_oe, port_g_oe}), 32'h15);
    wr(gpfg_pkg::ADDR_CTRL, 32'h2, gpfg_pkg::RESP_OKAY);
    chk("rst_sel", 32'({ext_reset_sel, port_f_oe}), 32'h9);
    end_sim();
  end
endmodule
